// ==== include/porseq_pkg.sv ====
// Purpose: constants and types for the power-on reset sequencer
// Assumes: local reference clock of 100 MHz drives ref_clk_i
// Notes:   hold-off count is derived from the time and the clock rate
// Behaviour
// - a low level on the power-on reset pin puts the device in reset
// - the pin acts asynchronously; a low pulse of 5 ns is caught
// - while in reset every register of the device takes its default
// - a reassertion at any time restores all defaults like power-up
// - after the pin goes high, reset is held a further 250 ms
package porseq_pkg;
    localparam int unsigned REF_CLK_HZ      = 100_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned HOLDOFF_TIME_MS = 250;
    // a longest hold-off is not asked for, so this exact product is used
    localparam int unsigned HOLDOFF_CYC     = HOLDOFF_TIME_MS * (REF_CLK_HZ / MS_PER_S);
    localparam int unsigned CNT_W           = $clog2(HOLDOFF_CYC + 1);

    typedef enum logic [1:0] {
        ST_ASSERT = 2'h0,
        ST_HOLD   = 2'h1,
        ST_RUN    = 2'h3
    } porseq_state_t;
endpackage : porseq_pkg

// ==== include/porseq_cnt_if.sv ====
// Purpose: control and status between sequencer and hold-off counter
// Assumes: all signals on ref_clk_i
// Notes:   clear forces the count to zero, run lets it advance
interface porseq_cnt_if;
    logic clear;
    logic run;
    logic done;

    modport ctl (output clear, output run, input  done);
    modport cnt (input  clear, input  run, output done);
endinterface : porseq_cnt_if

// ==== core/porseq_holdoff.sv ====
// Purpose: hold-off interval counter on the local reference clock
// Assumes: hold_cyc fits in CNT_W bits and is at least one
// Notes:   done is high in the last cycle of the interval
module porseq_holdoff
    import porseq_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HOLDOFF_CYC
) (
    input  wire logic  ref_clk_i,      // local reference clock
    input  wire logic  rst_b_i,        // synchronous reset, active low
    porseq_cnt_if.cnt  cnt             // control from the sequencer
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYC - 1);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (cnt.clear) begin
            count_d = '0;
        end else if (cnt.run && (count_q != LAST)) begin
            count_d = CNT_W'(count_q + 1'b1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign cnt.done = cnt.run && (count_q == LAST);

    property p_clear_restarts;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cnt.clear |=> (count_q == '0);
    endproperty
    a_clear_restarts: assert property (p_clear_restarts)
        else $error("hold-off count not restarted by clear");

    property p_count_steps;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cnt.run && !cnt.clear && !cnt.done) |=> (count_q == CNT_W'($past(count_q) + 1'b1));
    endproperty
    a_count_steps: assert property (p_count_steps)
        else $error("hold-off count did not advance by one");
endmodule : porseq_holdoff

// ==== core/porseq_top.sv ====
// Purpose: power-on reset sequencer with post-release hold-off
// Assumes: power_on_reset_n_i is an asynchronous pin, low means reset
// Notes:   reset entry is asynchronous, release is synchronous after hold-off
module porseq_top
    import porseq_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HOLDOFF_CYC
) (
    input  wire logic  ref_clk_i,           // local reference clock, 100 MHz
    input  wire logic  rst_b_i,             // synchronous reset, active low
    input  wire logic  power_on_reset_n_i,  // power-on reset pin, active low
    output logic       dev_rst_n_o,         // reset to the device core, active low
    output logic       defaults_load_o,     // registers take defaults while high
    output logic       holdoff_busy_o       // high during the hold-off interval
);
    porseq_cnt_if u_cnt_if ();

    porseq_holdoff #(
        .HOLD_CYC (HOLD_CYC)
    ) u_holdoff (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .cnt       (u_cnt_if.cnt)
    );

    // pin synchroniser: the pin clears it at once, release passes two flops
    logic meta_q;
    logic meta_d;
    logic pin_ok_q;
    logic pin_ok_d;

    // only the second flop reads the first; nothing else sees meta_q
    always_comb begin
        meta_d   = 1'b1;
        pin_ok_d = meta_q;
    end

    always_ff @(posedge ref_clk_i or negedge power_on_reset_n_i) begin
        if (!power_on_reset_n_i) begin
            meta_q   <= 1'b0;
            pin_ok_q <= 1'b0;
        end else begin
            meta_q   <= meta_d;
            pin_ok_q <= pin_ok_d;
        end
    end

    porseq_state_t state_q;
    porseq_state_t state_d;
    logic          dev_rst_n_q;
    logic          dev_rst_n_d;
    logic          dflt_q;
    logic          dflt_d;
    logic          busy_q;
    logic          busy_d;

    // state decodes shared by the outputs and the counter control
    function automatic logic st_is_run(input porseq_state_t st);
        return (st == ST_RUN);
    endfunction

    function automatic logic st_is_hold(input porseq_state_t st);
        return (st == ST_HOLD);
    endfunction

    always_comb begin
        state_d = state_q;
        if (!rst_b_i || !pin_ok_q) begin
            state_d = ST_ASSERT;
        end else begin
            unique case (state_q)
                ST_ASSERT: begin
                    state_d = ST_HOLD;
                end
                ST_HOLD: begin
                    if (u_cnt_if.done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_d = ST_RUN;
                end
                default: begin
                    state_d = ST_ASSERT;
                end
            endcase
        end
        dev_rst_n_d = st_is_run(state_d);
        dflt_d      = !st_is_run(state_d);
        busy_d      = st_is_hold(state_d);
    end

    // the pin forces reset without waiting for a clock edge
    always_ff @(posedge ref_clk_i or negedge power_on_reset_n_i) begin
        if (!power_on_reset_n_i) begin
            state_q     <= ST_ASSERT;
            dev_rst_n_q <= 1'b0;
            dflt_q      <= 1'b1;
            busy_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            dev_rst_n_q <= dev_rst_n_d;
            dflt_q      <= dflt_d;
            busy_q      <= busy_d;
        end
    end

    assign u_cnt_if.clear  = !st_is_hold(state_q);
    assign u_cnt_if.run    = st_is_hold(state_q);
    assign dev_rst_n_o     = dev_rst_n_q;
    // own flop rather than an inverter, so the output leaves a register
    assign defaults_load_o = dflt_q;
    assign holdoff_busy_o  = busy_q;

    // helper: length of the current hold-off interval
    logic [CNT_W:0] busy_len_q;
    logic [CNT_W:0] busy_len_d;

    always_comb begin
        busy_len_d = (CNT_W+1)'(busy_len_q + 1'b1);
        if (!rst_b_i || !holdoff_busy_o) begin
            busy_len_d = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        busy_len_q <= busy_len_d;
    end

    // checks run on the reference clock; the raw pin is only seen as a level

    property p_pin_low_resets;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !power_on_reset_n_i |-> (!dev_rst_n_o && !holdoff_busy_o);
    endproperty
    a_pin_low_resets: assert property (p_pin_low_resets)
        else $error("device not in reset while pin is low");

    property p_caught_low;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !pin_ok_q |-> (state_q != ST_RUN);
    endproperty
    a_caught_low: assert property (p_caught_low)
        else $error("caught reset pulse did not hold the device in reset");

    property p_defaults_track;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        defaults_load_o == (state_q != ST_RUN);
    endproperty
    a_defaults_track: assert property (p_defaults_track)
        else $error("defaults load does not follow the reset state");

    property p_reassert;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        ($past(dev_rst_n_o) && !power_on_reset_n_i) |-> (state_q == ST_ASSERT);
    endproperty
    a_reassert: assert property (p_reassert)
        else $error("reassertion during operation did not restore reset");

    property p_holdoff_len;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(dev_rst_n_o) |-> (busy_len_q == (CNT_W+1)'(HOLD_CYC));
    endproperty
    a_holdoff_len: assert property (p_holdoff_len)
        else $error("reset released without the full hold-off");

    property p_release_path;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(dev_rst_n_o) |-> ($past(holdoff_busy_o) && !holdoff_busy_o);
    endproperty
    a_release_path: assert property (p_release_path)
        else $error("reset released from outside the hold-off");

    // an aborted hold-off drops busy while the core is still held in reset
    property p_restart;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        ($past(holdoff_busy_o) && !holdoff_busy_o && !dev_rst_n_o)
            |-> (u_cnt_if.clear ##1 (busy_len_q == '0));
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold-off not restarted by a new reset");

    property p_defaults_inverse;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        defaults_load_o == !dev_rst_n_o;
    endproperty
    a_defaults_inverse: assert property (p_defaults_inverse)
        else $error("defaults load is not the inverse of the core reset");

    property p_busy_not_run;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !(holdoff_busy_o && dev_rst_n_o);
    endproperty
    a_busy_not_run: assert property (p_busy_not_run)
        else $error("core left reset while the hold-off still runs");

    // no disable here: the system reset itself is what is checked
    property p_sys_reset;
        @(posedge ref_clk_i)
        !rst_b_i |=> (!dev_rst_n_o && defaults_load_o && !holdoff_busy_o);
    endproperty
    a_sys_reset: assert property (p_sys_reset)
        else $error("system reset did not restore the reset state");

    property p_hold_entry;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(pin_ok_q) |=> (holdoff_busy_o || !pin_ok_q);
    endproperty
    a_hold_entry: assert property (p_hold_entry)
        else $error("hold-off did not start after the pin was released");

    property p_release_done;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(dev_rst_n_o) |-> $past(u_cnt_if.done);
    endproperty
    a_release_done: assert property (p_release_done)
        else $error("core released before the hold-off count completed");

    property p_run_stands;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        dev_rst_n_o |=> (dev_rst_n_o || !pin_ok_q);
    endproperty
    a_run_stands: assert property (p_run_stands)
        else $error("core reset asserted without a reset request");

    c_full_release:  cover property (@(posedge ref_clk_i) $rose(dev_rst_n_o));
    c_hold_abort:    cover property (@(posedge ref_clk_i) $fell(holdoff_busy_o) && !dev_rst_n_o);
    c_run_reassert:  cover property (@(posedge ref_clk_i) $fell(dev_rst_n_o));
    c_sys_reset:     cover property (@(posedge ref_clk_i) !rst_b_i && pin_ok_q);
endmodule : porseq_top

// ==== testbench/porseq_board.sv ====
// Purpose: board power-up circuit that drives the power-on reset pin
// Assumes: the pin has a pull-up, and the board holds it low from power-up
// Notes:   glitch drops the pin between two clock edges for a given width
module porseq_board (
    output logic power_on_reset_n_o  // power-on reset pin, active low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial power_on_reset_n_o = 1'b0;

    task automatic release_pin();
        #1 power_on_reset_n_o = 1'b1;
    endtask

    task automatic glitch(input int width_ns);
        #3 power_on_reset_n_o = 1'b0;
        #(width_ns) power_on_reset_n_o = 1'b1;
    endtask
endmodule // porseq_board

// ==== testbench/porseq_top_tb.sv ====
// Purpose: self-checking bench for the power-on reset sequencer
// Assumes: the hold-off is shortened to HOLD cycles
// Notes:   hold-off timing is counted in edges from the pin or system reset release
module porseq_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import porseq_pkg::*;
    localparam int unsigned HOLD = 8;
    logic ref_clk_i, rst_b_i, pin, dev_rst_n, dflt, busy;
    int   miscompares = 0;
    int   tests_run   = 0;

    porseq_top #(.HOLD_CYC(HOLD)) i_dut (
        .ref_clk_i          (ref_clk_i),
        .rst_b_i            (rst_b_i),
        .power_on_reset_n_i (pin),
        .dev_rst_n_o        (dev_rst_n),
        .defaults_load_o    (dflt),
        .holdoff_busy_o     (busy)
    );
    porseq_board i_board (.power_on_reset_n_o(pin));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic in_reset();
        check("dev_rst_n_o", 1'b0, dev_rst_n);
        check("defaults_load_o", 1'b1, dflt);
    endtask

    // busy from edge busy_at, normal operation from edge run_at
    task automatic measure(input int busy_at, input int run_at);
        for (int k = 1; k <= run_at; k++) begin
            @(posedge ref_clk_i);
            #1;
            check("holdoff_busy_o", k >= busy_at && k < run_at, busy);
            check("dev_rst_n_o", k >= run_at, dev_rst_n);
        end
        check("defaults_load_o", 1'b0, dflt);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        rst_b_i = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1 in_reset();
        $display("test pin held low done");
        @(posedge ref_clk_i);
        i_board.release_pin();
        measure(3, 3 + HOLD);
        $display("test power-up hold-off done");
        @(posedge ref_clk_i);
        fork
            i_board.glitch(5);
            begin
                #4 in_reset();
            end
        join
        measure(3, 3 + HOLD);
        $display("test short pulse in operation done");
        @(posedge ref_clk_i);
        i_board.glitch(5);
        repeat (5) @(posedge ref_clk_i);
        #1 check("holdoff_busy_o", 1'b1, busy);
        @(posedge ref_clk_i);
        i_board.glitch(5);
        measure(3, 3 + HOLD);
        $display("test restart during hold-off done");
        @(posedge ref_clk_i);
        rst_b_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 in_reset();
        check("holdoff_busy_o", 1'b0, busy);
        @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        measure(1, 1 + HOLD);
        $display("test system reset done");
        summarize();
    end
endmodule // porseq_top_tb
